// [rtl/asx_pkg.sv]
// Constants shared by the auxiliary stop input and strobe output block.
// Assumes a 100 MHz system clock and APB with 32-bit data.
package asx_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int STOP_QUAL_US = 50;
   localparam int STOP_QUAL_CYC = STOP_QUAL_US * CLK_MHZ;
   localparam int QCNT_W = 13;
   localparam int STRB_W = 32;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_SHUT = 8'h0C;
   localparam logic [7:0] OFS_STRB = 8'h10;
   localparam logic [7:0] OFS_IRQ = 8'h14;
   localparam logic [7:0] OFS_MASK = 8'h18;
   // ==========================================================
   // Fields
   localparam int MODE_W = 4;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam int CMD_RELEASE = 0;
   localparam int CMD_FORCE = 1;
   localparam int STRB_POL_BIT = 31;
   localparam int ST_STOP = 0;
   localparam int ST_JOYEN = 1;
   localparam int ST_PULSE = 2;
   localparam int ST_RAW = 3;
   localparam int EV_W = 3;
   localparam int EV_STOP = 0;
   localparam int EV_REL = 1;
   localparam int EV_PDONE = 2;
   localparam logic [EV_W-1:0] EV_RST = 3'h0;

   typedef enum logic [1:0] {
      ASX_IDLE = 2'b00,
      ASX_PULSE = 2'b01,
      ASX_DONE = 2'b11
   } asx_pst_t;
endpackage

// [rtl/asx_qual.sv]
// Stop input qualifier: level must hold for a minimum time.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/10ps
module asx_qual
   import asx_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic act,
   output logic qual
);
   logic [QCNT_W-1:0] cnt_r;
   localparam logic [QCNT_W-1:0] LIM = QCNT_W'(STOP_QUAL_CYC - 1);

   // [RL6] Min hold filter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         qual <= 1'b0;
      end else if (!act) begin
         cnt_r <= '0;
         qual <= 1'b0;
      end else if (cnt_r == LIM) begin
         qual <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   qual_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(qual) |-> $past(act, 1) && cnt_r == LIM) // [RL6]
      else $error("stop qualified too early");
endmodule

// [rtl/asx_top.sv]
// Auxiliary stop input conditioning, shutter level and strobe pulse.
// Assumes an APB master and synchronous pins on a 100 MHz clock.
// How it works
// [RL1] Modes 0,1: stop while asserted, joystick path stays on; 0 low, 1 high.
// [RL2] Modes 2,3: stop while asserted, joystick path off; 2 low, 3 high.
// [RL3] Modes 4,5: stop latched until release, joystick path off.
// [RL4] Mode register accepts 0..5 and 8..13 only.
// [RL5] Modes 8..13 mirror 0..5 but let a running move finish.
// [RL6] Stop input counts only after 50 us of steady assertion.
// [RL7] Command 0 releases, 1 forces stop, latched modes only.
// [RL8] Status reports 1 while a stop is in effect.
// [RL9] Shutter pin follows the written level, readable back.
// [RL10] Strobe makes one pulse, length in 10 ns clock cycles.
// [RL11] Sign picks active-high or active-low pulse and idle level.
// [RL12] Host should fire one dummy pulse at start to set idle level.
// [RL13] After reset latch is clear and strobe idles.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
module asx_top
   import asx_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_pin,
   input wire logic move_busy,
   output logic motion_halt,
   output logic manual_joystick_path,
   output logic shutter_out,
   output logic strobe_out,
   output logic irq
);
   // ==========================================================
   // Register bus decode
   logic [MODE_W-1:0] mode_r;
   logic shut_r, latch_r, halt_r, strobe_r, idle_lvl_r;
   logic [STRB_W-2:0] plen_r;
   logic [STRB_W-2:0] pcnt_r;
   logic [EV_W-1:0] ev_r, mask_r;
   asx_pst_t pst_r;

   wire setup = psel && !penable;
   // Writes land at the access edge, where the master sees pready
   wire access = psel && penable && pready;
   wire wr_en = access && pwrite;
   wire rd_en = setup && !pwrite;
   wire wr_mode = wr_en && paddr == OFS_MODE;
   wire wr_cmd = wr_en && paddr == OFS_CMD;
   wire wr_shut = wr_en && paddr == OFS_SHUT;
   wire wr_strb = wr_en && paddr == OFS_STRB;
   wire wr_irq = wr_en && paddr == OFS_IRQ;
   wire wr_mask = wr_en && paddr == OFS_MASK;
   wire mapped = paddr == OFS_MODE || paddr == OFS_CMD ||
      paddr == OFS_STAT || paddr == OFS_SHUT || paddr == OFS_STRB ||
      paddr == OFS_IRQ || paddr == OFS_MASK;

   function automatic logic mode_ok(input logic [MODE_W-1:0] m);
      return m <= 4'h5 || (m >= 4'h8 && m <= 4'hD);
   endfunction

   // ==========================================================
   // Mode decode
   wire [MODE_W-1:0] wmode = pwdata[MODE_W-1:0];
   wire [2:0] base = mode_r[3] ? 3'(mode_r - 4'h8) : mode_r[2:0];
   wire act_high = base[0];
   wire joy_off = base[2:1] != 2'b00;
   wire latched = base[2:1] == 2'b10;
   wire deferred = mode_r[3];
   wire raw_act = act_high ? stop_pin : !stop_pin;
   wire qual;

   asx_qual u_qual (
      .clk(clk),
      .arst_n(arst_n),
      .act(raw_act),
      .qual(qual)
   );

   wire cmd_rel = wr_cmd && latched && pwdata[CMD_RELEASE] == 1'b0;
   wire cmd_force = wr_cmd && latched && pwdata[CMD_FORCE-1] == 1'b1;
   wire stop_req = latched ? latch_r : qual;
   // Deferred modes wait for the running move to end
   wire halt_nxt = stop_req && !(deferred && move_busy);

   // ==========================================================
   // Control registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= MODE_RST;
         shut_r <= 1'b0;
         mask_r <= EV_RST;
      end else begin
         // [RL4] Reject modes 6, 7, 14 and 15
         if (wr_mode && mode_ok(wmode))
            mode_r <= wmode;
         // [RL9] Shutter level
         if (wr_shut)
            shut_r <= pwdata[0];
         if (wr_mask)
            mask_r <= pwdata[EV_W-1:0];
      end
   end

   // [RL3] Sticky stop latch
   // [RL7] Force or qualified set wins over release, which clears
   // [RL13] Latch clear at reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         latch_r <= 1'b0;
      else if (!latched)
         latch_r <= 1'b0;
      else if (cmd_force || qual)
         latch_r <= 1'b1;
      else if (cmd_rel)
         latch_r <= 1'b0;
   end

   // [RL1] Level stop, joystick kept
   // [RL2] Level stop, joystick off
   // [RL5] Deferred halt
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         halt_r <= 1'b0;
         manual_joystick_path <= 1'b1;
      end else begin
         halt_r <= halt_nxt;
         manual_joystick_path <= !joy_off;
      end
   end
   assign motion_halt = halt_r;
   assign shutter_out = shut_r;

   // ==========================================================
   // Strobe pulse generator
   wire pol_high = !pwdata[STRB_POL_BIT];
   wire [STRB_W-2:0] len_in = pwdata[STRB_W-2:0];

   // [RL10] Single timed pulse
   // [RL11] Polarity from sign
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pst_r <= ASX_IDLE;
         pcnt_r <= '0;
         plen_r <= '0;
         idle_lvl_r <= 1'b0;
         strobe_r <= 1'b0;
      end else begin
         case (pst_r)
            ASX_IDLE: begin
               if (wr_strb && len_in != '0) begin
                  idle_lvl_r <= !pol_high;
                  plen_r <= len_in;
                  pcnt_r <= len_in;
                  strobe_r <= pol_high;
                  pst_r <= ASX_PULSE;
               end
            end
            ASX_PULSE: begin
               if (pcnt_r == 1) begin
                  strobe_r <= idle_lvl_r;
                  pst_r <= ASX_DONE;
               end else begin
                  pcnt_r <= pcnt_r - 1'b1;
               end
            end
            ASX_DONE: pst_r <= ASX_IDLE;
            default: pst_r <= ASX_IDLE;
         endcase
      end
   end
   assign strobe_out = strobe_r;

   // ==========================================================
   // Events and interrupt
   logic halt_d_r;
   wire [EV_W-1:0] ev_set = {pst_r == ASX_DONE, cmd_rel && latch_r,
      halt_r && !halt_d_r};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ev_r <= EV_RST;
         halt_d_r <= 1'b0;
         irq <= 1'b0;
      end else begin
         halt_d_r <= halt_r;
         // Set wins over write-one-to-clear
         ev_r <= (ev_r & ~(wr_irq ? pwdata[EV_W-1:0] : EV_RST)) | ev_set;
         irq <= |(ev_r & mask_r);
      end
   end

   // ==========================================================
   // Read data, one wait-free access phase
   wire [31:0] stat_word = {28'h0, raw_act, pst_r == ASX_PULSE,
      manual_joystick_path, halt_r};
   wire [31:0] rd_mux =
      paddr == OFS_MODE ? {28'h0, mode_r} :
      paddr == OFS_STAT ? stat_word :
      paddr == OFS_SHUT ? {31'h0, shut_r} :
      paddr == OFS_STRB ? {idle_lvl_r, plen_r} :
      paddr == OFS_IRQ ? {29'h0, ev_r} :
      paddr == OFS_MASK ? {29'h0, mask_r} : 32'h0;

   // [RL8] Stop status readback
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (rd_en)
            prdata <= rd_mux;
      end
   end

   // ==========================================================
   // Checks
   mode_legal_a: assert property (@(posedge clk) disable iff (!arst_n)
      mode_r != 4'h6 && mode_r != 4'h7 && mode_r != 4'hE) // [RL4]
      else $error("illegal stop mode held");
   joy_kept_a: assert property (@(posedge clk) disable iff (!arst_n)
      base[2:1] == 2'b00 |=> manual_joystick_path) // [RL1]
      else $error("joystick dropped in level mode");
   joy_off_a: assert property (@(posedge clk) disable iff (!arst_n)
      $stable(mode_r) && joy_off |=> !manual_joystick_path) // [RL2]
      else $error("joystick kept in disabling mode");
   latch_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      latch_r && latched && !cmd_rel && $stable(mode_r) |=> latch_r)//[RL3]
      else $error("latched stop lost");
   force_set_a: assert property (@(posedge clk) disable iff (!arst_n)
      cmd_force |=> latch_r) // [RL7]
      else $error("force did not latch");
   defer_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
      deferred && move_busy |=> !halt_r) // [RL5]
      else $error("deferred stop cut a move");
   sequence pulse_start_s;
      wr_strb && pst_r == ASX_IDLE && len_in == 31'd3 && pol_high;
   endsequence
   pulse_len_a: assert property (@(posedge clk) disable iff (!arst_n)
      pulse_start_s |=> strobe_out [*3] ##1 !strobe_out) // [RL10]
      else $error("strobe length wrong");
   pulse_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
      pst_r == ASX_IDLE |-> strobe_out == idle_lvl_r) // [RL11]
      else $error("strobe idle level wrong");
   stat_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
      rd_en && paddr == OFS_STAT |=> prdata[ST_STOP] == $past(halt_r))//[RL8]
      else $error("stop status wrong");
endmodule

// [dv/asx_aux_dev.sv]
// Far-side model: stop switch and strobe width meter.
// Assumes the bench sets the switch and reads the last run lengths.
`timescale 1ns/10ps
module asx_aux_dev (
   input wire logic clk,
   input wire logic strobe_out,
   output logic stop_pin,
   output int hi_len,
   output int lo_len
);
   int hi = 0;
   int lo = 0;
   // Pull-up keeps an open switch high
   initial stop_pin = 1'b1;
   task automatic set_level(input logic l);
      stop_pin <= l;
   endtask
   // ==========================================
   // Width meter
   always @(posedge clk) begin
      if (strobe_out === 1'b1) begin
         hi++;
         if (lo != 0) lo_len = lo;
         lo = 0;
      end else begin
         lo++;
         if (hi != 0) hi_len = hi;
         hi = 0;
      end
   end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the stop, shutter and strobe block.
// Assumes the APB slave answers and a 100 MHz clock.
`timescale 1ns/10ps
module testbench;
   import asx_pkg::*;
   logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic move_busy = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic [31:0] prdata;
   logic pready, pslverr, stop_pin, motion_halt;
   logic manual_joystick_path, shutter_out, strobe_out, irq;
   int bad_count = 0, samples_checked = 0;
   always #5 clk = ~clk;
   asx_aux_dev AUX (.clk(clk), .strobe_out(strobe_out),
      .stop_pin(stop_pin), .hi_len(), .lo_len());
   asx_top DUT (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_pin(stop_pin), .move_busy(move_busy),
      .motion_halt(motion_halt),
      .manual_joystick_path(manual_joystick_path),
      .shutter_out(shutter_out), .strobe_out(strobe_out), .irq(irq));
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      logic ok;
      n = 0;
      ok = 1'b0;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // Answer is settled mid-cycle, before the edge that ends the access
      while (!ok && n < 50) begin
         @(negedge clk);
         n++;
         ok = (pready === 1'b1);
         rd = prdata;
         err = pslverr;
         @(posedge clk);
      end
      if (!ok) bad_count++;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      apb(0, OFS_STAT, 0);
      chk(rd[ST_STOP], 0);
      chk(strobe_out, 0);
      chk(manual_joystick_path, 1);
      apb(0, 8'h1C, 0);
      chk(err, 1);
   endtask
   task automatic t_mode;
      for (int m = 6; m < 16; m++) begin
         if (m == 8) m = 14;
         apb(1, OFS_MODE, m);
         apb(0, OFS_MODE, 0);
         chk(rd[3:0], 4'h0);
      end
   endtask
   task automatic t_level(input logic [3:0] m);
      AUX.set_level(!m[0]);
      apb(1, OFS_MODE, m);
      AUX.set_level(m[0]);
      wt(4990);
      chk(motion_halt, 0);
      apb(1, OFS_CMD, 1);
      wt(20);
      chk(motion_halt, 1);
      chk(manual_joystick_path, m < 4'h2);
      AUX.set_level(!m[0]);
      wt(10);
      chk(motion_halt, m[2]);
      apb(0, OFS_STAT, 0);
      chk(rd[ST_STOP], m[2]);
      apb(1, OFS_CMD, CMD_RELEASE);
      wt(3);
      chk(motion_halt, 0);
   endtask
   task automatic t_defer;
      AUX.set_level(0);
      apb(1, OFS_MODE, 13);
      move_busy <= 1;
      apb(1, OFS_CMD, CMD_FORCE);
      wt(5);
      chk(motion_halt, 0);
      move_busy <= 0;
      wt(5);
      chk(motion_halt, 1);
      apb(1, OFS_CMD, CMD_RELEASE);
      wt(3);
      chk(motion_halt, 0);
   endtask
   task automatic t_shut;
      for (int v = 1; v >= 0; v--) begin
         apb(1, OFS_SHUT, v);
         wt(1);
         chk(shutter_out, v);
         apb(0, OFS_SHUT, 0);
         chk(rd[0], v);
      end
   endtask
   task automatic pulse(input int len, input logic neg);
      apb(1, OFS_STRB, {neg, 31'(len)});
      wt(len + 6);
   endtask
   task automatic t_strobe;
      apb(1, OFS_MASK, 0);
      apb(1, OFS_IRQ, 7);
      pulse(1, 0);
      chk(AUX.hi_len, 1);
      pulse(3, 0);
      chk(AUX.hi_len, 3);
      chk(irq, 0);
      pulse(3, 1);
      pulse(7, 1);
      chk(AUX.lo_len, 7);
      chk(strobe_out, 1);
      apb(0, OFS_IRQ, 0);
      chk(rd[EV_PDONE], 1);
      apb(1, OFS_MASK, 7);
      wt(2);
      chk(irq, 1);
      apb(1, OFS_IRQ, 7);
      wt(2);
      chk(irq, 0);
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      wt(20);
      arst_n <= 1;
      t_reset();
      t_mode();
      for (int m = 0; m < 6; m++) t_level(m[3:0]);
      t_defer();
      t_shut();
      t_strobe();
      conclude();
   end
   initial begin
      wt(60000);
      bad_count++;
      conclude();
   end
endmodule
